// ### verilog/est_pkg.sv
`default_nettype none
package est_pkg;
   // ****************************************************************
   // register indices of the device (16-bit registers)
   // ****************************************************************
   localparam logic [7:0] EST_HBLANK_IDX = 8'h05; // horizontal_blank_reg
   localparam logic [7:0] EST_VBLANK_IDX = 8'h06; // vertical_blank_reg
   localparam logic [7:0] EST_SW_UP_IDX = 8'h08; // shutter_width_upper
   localparam logic [7:0] EST_SW_LO_IDX = 8'h09; // shutter_width_lower
   localparam logic [7:0] EST_RESTART_IDX = 8'h0B; // restart_reg
   localparam logic [7:0] EST_SUBROW_IDX = 8'h0C; // shutter_delay_subrow
   localparam logic [7:0] EST_SNAP_IDX = 8'h1E; // snapshot_control_reg
   localparam logic [7:0] EST_GS_IDX = 8'h21; // global_shutter_mode_reg
   localparam logic [7:0] EST_HEIGHT_IDX = 8'h03; // output image rows - 1
   // ****************************************************************
   // reset values and fields
   // ****************************************************************
   localparam logic [15:0] EST_HBLANK_RST = 16'h008E;
   localparam logic [15:0] EST_VBLANK_RST = 16'h0019;
   localparam logic [15:0] EST_SW_LO_RST = 16'h0619;
   localparam logic [15:0] EST_HEIGHT_RST = 16'h05FF;
   localparam int EST_SNAP_EN_BIT = 8;
   localparam int EST_STROBE_EN_BIT = 9;
   localparam int EST_STROBE_LONG_BIT = 10;
   localparam int EST_RESTART_BIT = 0;
   localparam logic [15:0] EST_GS_PROG = 16'h0003;
   localparam logic [15:0] EST_GS_BULB = 16'h0001;
   // ****************************************************************
   // timing figures, in pixel clocks unless noted
   // ****************************************************************
   localparam int EST_HBLANK_MIN = 21; // least legal setting
   localparam logic [15:0] EST_HBLANK_ADD = 16'h0171; // 511-142, 390-21
   localparam int EST_VBLANK_ADD = 1; // 0x19 gives 26 rows
   localparam int EST_SUBROW_ADD = 132;
   localparam int EST_GS_RESET_CLK = 18820;
   localparam int EST_EXP_START_CLK = 1000;
   localparam int EST_PROG_TAIL_CLK = 2000;
   localparam int EST_READ_WAIT_ROWS = 16;
   localparam int EST_STROBE_SUB_ROWS = 16;
   localparam int EST_SW_UPPER_SHIFT = 16; // weight 65536
   // ****************************************************************
   // sequencer states
   // ****************************************************************
   typedef enum logic [3:0] {
      EST_IDLE = 4'h0,
      EST_ROWRST = 4'h1,
      EST_STROBE = 4'h3,
      EST_WAIT = 4'h2,
      EST_READ = 4'h6,
      EST_VBLANK = 4'h7,
      EST_GS_EXP = 4'h5,
      EST_GS_TAIL = 4'h4
   } est_state_t;
endpackage : est_pkg
`default_nettype wire

// ### verilog/est_if.sv
`timescale 1ns/1ps
`default_nettype none
interface est_if;
   logic trigger; // external trigger, falling edge starts a snapshot
   logic global_shutter_control_pin; // global_shutter_control_pin
   logic [7:0] reg_addr; // device register index
   logic [15:0] reg_wdata; // write data
   logic reg_we; // one-cycle write strobe
   logic reg_re; // one-cycle read strobe
   logic [15:0] reg_rdata; // read data, cycle after reg_re
   logic strobe; // flash strobe
   logic frame_valid; // rows being read out
   logic exposing; // integration in progress
   modport dev (input trigger, global_shutter_control_pin, reg_addr, reg_wdata, reg_we,
      reg_re, output reg_rdata, strobe, frame_valid, exposing);
   modport host (output trigger, global_shutter_control_pin, reg_addr, reg_wdata, reg_we,
      reg_re, input reg_rdata, strobe, frame_valid, exposing);
endinterface : est_if
`default_nettype wire

// ### verilog/est_device.sv
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module est_device #(
   parameter int ARRAY_ROWS = 1536, // rows reset in sequence
   parameter int ROW_OVERHEAD = 0 // row_overhead_term in clocks
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   // link to host
   est_if.dev bus,
   // user side
   output logic o_exposing,
   output logic [31:0] o_int_clk, // trimmed integration, clocks
   output logic [15:0] o_row_clk // row_period in clocks
);
   // ****************************************************************
   // registers
   // ****************************************************************
   logic [15:0] hblank_r, vblank_r, sw_up_r, sw_lo_r, subrow_r;
   logic [15:0] snap_r, gs_r, height_r, rdata_r;
   logic restart_r, kick; // self-clearing start bit, start taken
   // register writes; restart clears when the start is taken
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         hblank_r <= est_pkg::EST_HBLANK_RST;
         vblank_r <= est_pkg::EST_VBLANK_RST;
         sw_up_r <= 16'h0000;
         sw_lo_r <= est_pkg::EST_SW_LO_RST;
         subrow_r <= 16'h0000;
         snap_r <= 16'h0000;
         gs_r <= 16'h0000;
         height_r <= est_pkg::EST_HEIGHT_RST;
         restart_r <= 1'b0;
      end else if (i_ce) begin
         if (bus.reg_we) begin
            unique case (bus.reg_addr)
               est_pkg::EST_HBLANK_IDX: hblank_r <= bus.reg_wdata;
               est_pkg::EST_VBLANK_IDX: vblank_r <= bus.reg_wdata;
               est_pkg::EST_SW_UP_IDX: sw_up_r <= bus.reg_wdata;
               est_pkg::EST_SW_LO_IDX: sw_lo_r <= bus.reg_wdata;
               est_pkg::EST_SUBROW_IDX: subrow_r <= bus.reg_wdata;
               est_pkg::EST_SNAP_IDX: snap_r <= bus.reg_wdata;
               est_pkg::EST_GS_IDX: gs_r <= bus.reg_wdata;
               est_pkg::EST_HEIGHT_IDX: height_r <= bus.reg_wdata;
               default: ;
            endcase
         end
         // a fresh write wins over the clear
         if (bus.reg_we && bus.reg_addr == est_pkg::EST_RESTART_IDX)
            restart_r <= bus.reg_wdata[est_pkg::EST_RESTART_BIT];
         else if (kick)
            restart_r <= 1'b0;
      end
   end
   // read data one cycle after the strobe
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         rdata_r <= 16'h0000;
      end else if (i_ce) begin
         rdata_r <= 16'h0000;
         if (bus.reg_re) begin
            unique case (bus.reg_addr)
               est_pkg::EST_HBLANK_IDX: rdata_r <= hblank_r;
               est_pkg::EST_VBLANK_IDX: rdata_r <= vblank_r;
               est_pkg::EST_SW_UP_IDX: rdata_r <= sw_up_r;
               est_pkg::EST_SW_LO_IDX: rdata_r <= sw_lo_r;
               est_pkg::EST_SUBROW_IDX: rdata_r <= subrow_r;
               est_pkg::EST_SNAP_IDX: rdata_r <= snap_r;
               est_pkg::EST_GS_IDX: rdata_r <= gs_r;
               est_pkg::EST_HEIGHT_IDX: rdata_r <= height_r;
               est_pkg::EST_RESTART_IDX: rdata_r <= {15'h0000, restart_r};
               default: rdata_r <= 16'h0000;
            endcase
         end
      end
   end
   assign bus.reg_rdata = rdata_r;
   // ****************************************************************
   // derived timing
   // ****************************************************************
   logic [31:0] sw_rows, frame_rows, long_rows; // shutter, frame, strobe rows
   logic snap_en, gs_prog, gs_bulb, strobe_ok;
   assign o_row_clk = 16'(2048 + hblank_r) + est_pkg::EST_HBLANK_ADD;
   assign sw_rows = {sw_up_r, 16'h0000} + {16'h0000, sw_lo_r};
   assign frame_rows = 32'(height_r) + 32'd1 + 32'(vblank_r)
      + 32'(est_pkg::EST_VBLANK_ADD);
   assign o_int_clk = 32'(sw_rows * o_row_clk) - 32'(subrow_r)
      - 32'(ROW_OVERHEAD) + 32'(est_pkg::EST_SUBROW_ADD);
   assign long_rows = sw_rows - frame_rows
      - 32'(est_pkg::EST_STROBE_SUB_ROWS);
   assign snap_en = snap_r[est_pkg::EST_SNAP_EN_BIT];
   assign gs_prog = (gs_r == est_pkg::EST_GS_PROG);
   assign gs_bulb = (gs_r == est_pkg::EST_GS_BULB);
   assign strobe_ok = snap_r[est_pkg::EST_STROBE_EN_BIT]
      && (sw_rows > frame_rows);
   // ****************************************************************
   // pin synchronisers and edges
   // ****************************************************************
   logic [1:0] trig_s, gsht_s;
   logic trig_d, gsht_d, trig_fall, gsht_fall;
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         trig_s <= 2'h3;
         gsht_s <= 2'h0;
         trig_d <= 1'b1;
         gsht_d <= 1'b0;
      end else if (i_ce) begin
         trig_s <= {trig_s[0], bus.trigger};
         gsht_s <= {gsht_s[0], bus.global_shutter_control_pin};
         trig_d <= trig_s[1];
         gsht_d <= gsht_s[1];
      end
   end
   assign trig_fall = trig_d & ~trig_s[1];
   assign gsht_fall = gsht_d & ~gsht_s[1];
   // ****************************************************************
   // sequencer
   // ****************************************************************
   est_pkg::est_state_t st_r;
   logic [31:0] clk_cnt_r, row_cnt_r, gs_tail_r; // phase clocks, rows, tail
   logic strobe_r, bulb_r, row_end;
   assign row_end = (clk_cnt_r[15:0] == o_row_clk - 16'h0001);
   // restart ignored in global shutter modes
   assign kick = (st_r == est_pkg::EST_IDLE) && snap_en && !gs_prog
      && !gs_bulb && (trig_fall || restart_r);
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         st_r <= est_pkg::EST_IDLE;
         clk_cnt_r <= 32'h0000_0000;
         row_cnt_r <= 32'h0000_0000;
         gs_tail_r <= 32'h0000_0000;
         strobe_r <= 1'b0;
         bulb_r <= 1'b0;
      end else if (i_ce) begin
         clk_cnt_r <= row_end ? 32'h0000_0000 : clk_cnt_r + 32'd1;
         unique case (st_r)
            est_pkg::EST_IDLE: begin
               if (kick) begin
                  st_r <= est_pkg::EST_ROWRST;
                  clk_cnt_r <= 32'h0000_0000;
                  row_cnt_r <= 32'h0000_0000;
               end else if (snap_en && gs_prog && gsht_fall) begin
                  st_r <= est_pkg::EST_GS_EXP;
                  bulb_r <= 1'b0;
                  clk_cnt_r <= 32'h0000_0000;
                  gs_tail_r <= 32'(sw_rows * o_row_clk)
                     + 32'(est_pkg::EST_PROG_TAIL_CLK);
               end else if (snap_en && gs_bulb && gsht_fall) begin
                  st_r <= est_pkg::EST_GS_EXP;
                  bulb_r <= 1'b1;
                  clk_cnt_r <= 32'h0000_0000;
               end
            end
            est_pkg::EST_ROWRST: begin
               if (row_end) begin
                  row_cnt_r <= row_cnt_r + 32'd1;
                  if (row_cnt_r == 32'(ARRAY_ROWS - 1)) begin
                     row_cnt_r <= 32'h0000_0000;
                     st_r <= est_pkg::EST_STROBE;
                     strobe_r <= strobe_ok;
                  end
               end
            end
            est_pkg::EST_STROBE: begin
               if (row_end) begin
                  row_cnt_r <= row_cnt_r + 32'd1;
                  // long width only if the strobe is active
                  if (!snap_r[est_pkg::EST_STROBE_LONG_BIT] || !strobe_ok
                      || row_cnt_r + 32'd1 >= long_rows) begin
                     strobe_r <= 1'b0;
                     row_cnt_r <= 32'h0000_0000;
                     st_r <= est_pkg::EST_WAIT;
                  end
               end
            end
            est_pkg::EST_WAIT: begin
               if (row_end) begin
                  row_cnt_r <= row_cnt_r + 32'd1;
                  if (row_cnt_r == 32'(est_pkg::EST_READ_WAIT_ROWS - 1)) begin
                     row_cnt_r <= 32'h0000_0000;
                     st_r <= est_pkg::EST_READ;
                  end
               end
            end
            est_pkg::EST_GS_EXP: begin
               // start delay saturates; bulb ends on the trigger fall
               clk_cnt_r <= clk_cnt_r + ((clk_cnt_r
                  < 32'(est_pkg::EST_EXP_START_CLK)) ? 32'd1 : 32'd0);
               if (bulb_r && trig_fall) begin
                  st_r <= est_pkg::EST_GS_TAIL;
                  clk_cnt_r <= 32'h0000_0000;
                  gs_tail_r <= 32'(sw_rows * o_row_clk);
                  strobe_r <= strobe_ok;
               end else if (!bulb_r) begin
                  st_r <= est_pkg::EST_GS_TAIL;
                  strobe_r <= strobe_ok;
               end
            end
            est_pkg::EST_GS_TAIL: begin
               clk_cnt_r <= clk_cnt_r + 32'd1;
               if (clk_cnt_r + 32'd1 >= gs_tail_r) begin
                  strobe_r <= 1'b0;
                  clk_cnt_r <= 32'h0000_0000;
                  row_cnt_r <= (32'(vblank_r) + 32'd1
                     < 32'(est_pkg::EST_READ_WAIT_ROWS))
                     ? 32'(est_pkg::EST_READ_WAIT_ROWS) - 32'(vblank_r)
                     - 32'd1 : 32'h0000_0000;
                  st_r <= est_pkg::EST_WAIT;
               end
            end
            est_pkg::EST_READ: begin
               if (row_end) begin
                  row_cnt_r <= row_cnt_r + 32'd1;
                  if (row_cnt_r == 32'(height_r)) begin
                     row_cnt_r <= 32'h0000_0000;
                     st_r <= est_pkg::EST_VBLANK;
                  end
               end
            end
            est_pkg::EST_VBLANK: begin
               // extra rows when shutter exceeds the frame
               if (row_end) begin
                  row_cnt_r <= row_cnt_r + 32'd1;
                  if (row_cnt_r + 32'd1 >= 32'(vblank_r)
                      + 32'(est_pkg::EST_VBLANK_ADD)
                      && row_cnt_r + 32'd1 + 32'(height_r) + 32'd1
                      >= sw_rows) begin
                     row_cnt_r <= 32'h0000_0000;
                     st_r <= est_pkg::EST_IDLE;
                  end
               end
            end
            default: st_r <= est_pkg::EST_IDLE;
         endcase
      end
   end
   // exposure flag: both global modes start 1000 clocks after the fall
   assign o_exposing = (st_r == est_pkg::EST_GS_TAIL && !bulb_r
      && clk_cnt_r >= 32'(est_pkg::EST_EXP_START_CLK))
      || (st_r == est_pkg::EST_GS_EXP && bulb_r
      && clk_cnt_r >= 32'(est_pkg::EST_EXP_START_CLK))
      || st_r == est_pkg::EST_STROBE;
   assign bus.exposing = o_exposing;
   assign bus.strobe = strobe_r;
   assign bus.frame_valid = (st_r == est_pkg::EST_READ);
endmodule : est_device
`default_nettype wire

// ### verilog/est_host.sv
`timescale 1ns/1ps
`default_nettype none
module est_host #(
   parameter int RESET_CLK = est_pkg::EST_GS_RESET_CLK // array reset hold
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   // register command port
   input wire logic [7:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_we,
   input wire logic i_re,
   output logic [15:0] o_rdata,
   // pin sequence commands
   input wire logic i_prog_go, // programmed exposure sequence
   input wire logic i_bulb_go, // start bulb sequence
   input wire logic i_bulb_end, // end bulb exposure
   input wire logic i_trig_pulse, // plain snapshot trigger
   output logic o_busy,
   // link
   est_if.host bus
);
   // ****************************************************************
   // pin sequencer
   // ****************************************************************
   logic trig_r, gsht_r, hold_r;
   logic [31:0] cnt_r;
   assign bus.reg_addr = i_addr;
   assign bus.reg_wdata = i_wdata;
   assign bus.reg_we = i_we;
   assign bus.reg_re = i_re;
   assign o_rdata = bus.reg_rdata;
   assign bus.trigger = trig_r;
   assign bus.global_shutter_control_pin = gsht_r;
   assign o_busy = hold_r;
   // hold the shutter pin high for the array reset time, then drop it
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         trig_r <= 1'b1; // rests high, so no false fall after reset
         gsht_r <= 1'b0;
         hold_r <= 1'b0;
         cnt_r <= 32'h0000_0000;
      end else if (i_ce) begin
         if (hold_r) begin
            cnt_r <= cnt_r + 32'd1;
            if (cnt_r == 32'(RESET_CLK - 1)) begin
               hold_r <= 1'b0;
               gsht_r <= 1'b0;
            end
         end else if (i_prog_go) begin
            gsht_r <= 1'b1;
            hold_r <= 1'b1;
            cnt_r <= 32'h0000_0000;
         end else if (i_bulb_go) begin
            gsht_r <= 1'b1;
            trig_r <= 1'b1;
            hold_r <= 1'b1;
            cnt_r <= 32'h0000_0000;
         end else if (i_bulb_end) begin
            trig_r <= 1'b0;
         end else if (i_trig_pulse) begin
            trig_r <= ~trig_r; // one pulse from rest falls
         end
      end
   end
endmodule : est_host
`default_nettype wire

// ### sim/est_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module est_chk_sva #(
   parameter int RESET_CLK = 20 // pin hold given to the host
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset,
   // link signals
   input wire logic trigger,
   input wire logic global_shutter_control_pin,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   input wire logic [15:0] reg_rdata,
   input wire logic strobe,
   input wire logic frame_valid,
   input wire logic exposing
);
   // ****
   // shadow state
   // ****
   logic [15:0] snap_r; // snapshot_control_reg copy
   logic [15:0] hb_r; // horizontal_blank_reg copy
   logic [15:0] gs_r; // global_shutter_mode_reg copy
   logic [31:0] st_r; // clocks strobe has been high
   logic [31:0] hi_r; // clocks shutter pin has been high
   logic [31:0] gap_r; // clocks since strobe fell
   logic arm_r; // a strobe came before this readout
   logic [31:0] row_w; // row_period: 2048 + hblank + 369
   assign row_w = 32'(hb_r) + 32'h0000_0971;
   // copies follow host writes; defaults match the device
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         snap_r <= 16'h0000;
         hb_r <= est_pkg::EST_HBLANK_RST;
         gs_r <= 16'h0000;
      end else if (reg_we) begin
         case (reg_addr)
            est_pkg::EST_SNAP_IDX: snap_r <= reg_wdata;
            est_pkg::EST_HBLANK_IDX: hb_r <= reg_wdata;
            est_pkg::EST_GS_IDX: gs_r <= reg_wdata;
            default: ;
         endcase
      end
   end
   // run lengths; zero after reset so a stale edge is skipped
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         st_r <= 32'h0;
         hi_r <= 32'h0;
      end else begin
         st_r <= strobe ? st_r + 32'h1 : 32'h0;
         hi_r <= global_shutter_control_pin ? hi_r + 32'h1 : 32'h0;
      end
   end
   // readout wait is timed from the last strobe fall
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         gap_r <= 32'h0;
         arm_r <= 1'b0;
      end else if (strobe) begin
         gap_r <= 32'h0;
         arm_r <= 1'b1;
      end else if (frame_valid) begin
         arm_r <= 1'b0;
      end else begin
         gap_r <= gap_r + 32'h1;
      end
   end
   // clocks since the shutter pin fell; zero before any fall
   logic gs_d_r; // shutter pin one clock ago
   logic [10:0] since_r; // saturates, so a stale fall never wraps
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         gs_d_r <= 1'b0;
         since_r <= 11'h000;
      end else begin
         gs_d_r <= global_shutter_control_pin;
         if (gs_d_r && !global_shutter_control_pin)
            since_r <= 11'h001;
         else if (since_r != 11'h000 && since_r != 11'h7FF)
            since_r <= since_r + 11'h001;
      end
   end
   // ****
   // properties
   // ****
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   a_strobe_needs_en: assert property (strobe |-> snap_r[9])
      else $error("strobe while strobe output disabled");
   a_strobe_needs_snap: assert property (strobe |-> snap_r[8])
      else $error("strobe while snapshot mode off");
   a_snap_readback: assert property ($past(reg_re) &&
      $past(reg_addr) == est_pkg::EST_SNAP_IDX |-> reg_rdata == snap_r)
      else $error("snapshot control readback wrong");
   a_strobe_no_read: assert property (strobe |-> !frame_valid)
      else $error("readout during strobe");
   a_strobe_one_row: assert property ($fell(strobe) &&
      st_r != 32'h0 && !snap_r[10] |-> st_r == row_w)
      else $error("short strobe not one row long");
   a_read_waits_rows: assert property ($rose(frame_valid) &&
      arm_r && gs_r == 16'h0000 |->
      gap_r + 32'h2 >= 32'h10 * row_w && gap_r <= 32'h10 * row_w + 32'h4)
      else $error("readout wait after strobe wrong");
   a_exp_start: assert property ($rose(exposing) &&
      (gs_r == est_pkg::EST_GS_PROG || gs_r == est_pkg::EST_GS_BULB)
      |-> since_r >= 11'h3E8 && since_r <= 11'h3EE)
      else $error("exposure start delay wrong");
   a_exp_not_late: assert property (since_r == 11'h3EE && trigger &&
      (gs_r == est_pkg::EST_GS_PROG || gs_r == est_pkg::EST_GS_BULB)
      |-> exposing)
      else $error("exposure did not start in time");
   a_gs_hold_len: assert property ($fell(global_shutter_control_pin) &&
      hi_r != 32'h0 && gs_r == est_pkg::EST_GS_PROG |-> hi_r >= RESET_CLK)
      else $error("shutter pin held too briefly");
   c_strobe: cover property ($rose(strobe));
   c_readout: cover property ($rose(frame_valid));
   c_exposure: cover property ($rose(exposing));
endmodule : est_chk_sva
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // ****
   // stimulus, observed signals, bookkeeping
   // ****
   logic i_core_clk = 1'b0; // 50 MHz
   logic i_reset = 1'b1; // held for the first two edges
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic we = 1'b0;
   logic re = 1'b0;
   logic ce = 1'b1; // clock enable to both ends
   logic [3:0] go = 4'h0; // prog, bulb, bulb end, trigger commands
   logic [15:0] rdata;
   logic busy;
   logic exposing;
   logic [31:0] int_clk;
   logic [15:0] row_clk;
   int mismatches = 0;
   int comparisons = 0;
   int cyc = 0; // clocks since start
   int row = 2438; // row period with hblank at its least value 21
   // snapshot cases: shutter rows, mode word, strobe expected
   logic [15:0] sw_t [4] = '{16'h0004, 16'h0003, 16'h0004, 16'h0004};
   logic [15:0] sn_t [4] = '{16'h0300, 16'h0300, 16'h0100, 16'h0200};
   logic ex_t [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
   always #10 i_core_clk = ~i_core_clk;
   est_if u_est_if ();
   // one reset row keeps a full frame within the run budget
   est_device #(.ARRAY_ROWS(1), .ROW_OVERHEAD(5)) u_est_device (
      .i_core_clk(i_core_clk), .i_reset(i_reset), .i_ce(ce),
      .bus(u_est_if), .o_exposing(exposing), .o_int_clk(int_clk),
      .o_row_clk(row_clk));
   est_host #(.RESET_CLK(20)) u_est_host (
      .i_core_clk(i_core_clk), .i_reset(i_reset), .i_ce(ce),
      .i_addr(addr), .i_wdata(wdata), .i_we(we), .i_re(re),
      .o_rdata(rdata), .i_prog_go(go[0]), .i_bulb_go(go[1]),
      .i_bulb_end(go[2]), .i_trig_pulse(go[3]), .o_busy(busy),
      .bus(u_est_if));
   est_chk_sva #(.RESET_CLK(20)) u_est_chk_sva (
      .i_core_clk(i_core_clk), .i_reset(i_reset),
      .trigger(u_est_if.trigger), .global_shutter_control_pin(u_est_if.global_shutter_control_pin),
      .reg_addr(u_est_if.reg_addr), .reg_wdata(u_est_if.reg_wdata),
      .reg_we(u_est_if.reg_we), .reg_re(u_est_if.reg_re),
      .reg_rdata(u_est_if.reg_rdata), .strobe(u_est_if.strobe),
      .frame_valid(u_est_if.frame_valid), .exposing(u_est_if.exposing));
   // ****
   // helpers
   // ****
   task end_sim();
      if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // a hang counts as a failure
   always @(posedge i_core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         mismatches++;
         end_sim();
      end
   end
   function automatic logic pin(input int k);
      case (k)
         0: return u_est_if.global_shutter_control_pin;
         1: return u_est_if.trigger;
         2: return u_est_if.exposing;
         3: return u_est_if.frame_valid;
         default: return u_est_if.strobe;
      endcase
   endfunction : pin
   // polls on falling edges, where outputs have settled
   task wait_lvl(input int k, input logic v, input int lim,
      output logic hit, output int t);
      int n;
      n = 0;
      do begin
         @(negedge i_core_clk);
         n++;
      end while (pin(k) !== v && n < lim);
      hit = (pin(k) === v);
      t = cyc;
   endtask : wait_lvl
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_core_clk);
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge i_core_clk);
      we <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task rd(input logic [7:0] a, input logic [15:0] exp, input string nm);
      @(posedge i_core_clk);
      addr <= a;
      re <= 1'b1;
      @(posedge i_core_clk);
      re <= 1'b0;
      @(negedge i_core_clk);
      chk(nm, rdata, exp);
   endtask : rd
   task pulse(input int k);
      @(posedge i_core_clk);
      go <= 4'h1 << k;
      @(posedge i_core_clk);
      go <= 4'h0;
   endtask : pulse
   task do_reset();
      @(posedge i_core_clk);
      i_reset <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      i_reset <= 1'b0;
   endtask : do_reset
   // short frame: two image rows, one blank row, least hblank
   task setup(input logic [15:0] sw, input logic [15:0] snap);
      wr(est_pkg::EST_HBLANK_IDX, 16'h0015);
      wr(est_pkg::EST_VBLANK_IDX, 16'h0000);
      wr(est_pkg::EST_HEIGHT_IDX, 16'h0001);
      wr(est_pkg::EST_SW_LO_IDX, sw);
      wr(est_pkg::EST_SNAP_IDX, snap);
   endtask : setup
   // ****
   // scenarios
   // ****
   task t_regs();
      rd(est_pkg::EST_HBLANK_IDX, est_pkg::EST_HBLANK_RST, "hblank");
      rd(est_pkg::EST_VBLANK_IDX, est_pkg::EST_VBLANK_RST, "vblank");
      rd(8'h7F, 16'h0000, "unmapped");
      // a write while the clock enable is low must be lost
      @(posedge i_core_clk);
      ce <= 1'b0;
      wr(est_pkg::EST_VBLANK_IDX, 16'h0005);
      ce <= 1'b1;
      rd(est_pkg::EST_VBLANK_IDX, est_pkg::EST_VBLANK_RST, "frozen");
      chk("row default", row_clk, 2048 + 511);
      wr(est_pkg::EST_HBLANK_IDX, 16'h0015);
      wr(est_pkg::EST_SW_UP_IDX, 16'h0001);
      wr(est_pkg::EST_SW_LO_IDX, 16'h0002);
      wr(est_pkg::EST_SUBROW_IDX, 16'h0010);
      repeat (3) @(negedge i_core_clk);
      chk("row minimum", row_clk, 2048 + 390);
      chk("integration", int_clk, 65538 * row - 16 - 5 + 132);
   endtask : t_regs
   task t_cases();
      logic hit;
      int t0;
      int t1;
      for (int i = 0; i < 4; i++) begin
         do_reset();
         setup(sw_t[i], sn_t[i]);
         pulse(3);
         wait_lvl(1, 1'b0, 50, hit, t0);
         wait_lvl(4, 1'b1, row + 300, hit, t1);
         chk("strobe", hit, ex_t[i]);
         if (ex_t[i]) chk("row reset", t1 - t0 >= row, 1'b1);
      end
   endtask : t_cases
   task t_frame();
      logic hit;
      int t1;
      int t2;
      int t3;
      do_reset();
      setup(16'h0004, 16'h0300);
      rd(est_pkg::EST_SNAP_IDX, 16'h0300, "snap mode");
      wr(est_pkg::EST_RESTART_IDX, 16'h0001);
      repeat (2) @(posedge i_core_clk);
      rd(est_pkg::EST_RESTART_IDX, 16'h0000, "restart");
      wait_lvl(4, 1'b1, 2 * row, hit, t1);
      wait_lvl(4, 1'b0, 2 * row, hit, t2);
      chk("strobe width", t2 - t1, row);
      wait_lvl(3, 1'b1, 17 * row, hit, t3);
      chk("read wait", t3 - t2 >= 16 * row && t3 - t2 <= 16 * row + 4, 1);
   endtask : t_frame
   task t_gs(input logic bulb);
      logic hit;
      int tg;
      int te;
      int tf;
      int ex; // clocks from the reference edge to readout
      do_reset();
      setup(16'h0001, 16'h0100);
      wr(est_pkg::EST_GS_IDX, bulb ? est_pkg::EST_GS_BULB : est_pkg::EST_GS_PROG);
      wr(est_pkg::EST_RESTART_IDX, 16'h0001);
      wait_lvl(2, 1'b1, 300, hit, te);
      chk("restart ignored", hit, 1'b0);
      pulse(bulb ? 1 : 0);
      wait_lvl(0, 1'b1, 50, hit, tg);
      wait_lvl(0, 1'b0, 100, hit, tg);
      wait_lvl(2, 1'b1, 1100, hit, te);
      chk("exposure", te - tg >= 1000 && te - tg <= 1006, 1'b1);
      ex = 2 * row + 2000;
      if (bulb) begin
         pulse(2);
         wait_lvl(1, 1'b0, 50, hit, tg);
         ex = 2 * row;
      end
      wait_lvl(3, 1'b1, ex + 100, hit, tf);
      chk("readout", tf - tg >= ex - 2 && tf - tg <= ex + 6, 1);
   endtask : t_gs
   // main sequence; the run ends only through end_sim
   initial begin
      repeat (2) @(posedge i_core_clk);
      i_reset <= 1'b0;
      t_regs();
      t_cases();
      t_frame();
      t_gs(1'b0);
      t_gs(1'b1);
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
